// File: shared/epr_pkg.sv
// constants and types shared by both ends of the protect-register link
`default_nettype none
package epr_pkg;
   // ------------------------------------------------------------
   // frame layout: start bit, opcode, address, msb first
   // ------------------------------------------------------------
   localparam int ADDR_W = 8;               // protect register and address width
   localparam int OP_W = 2;                 // opcode width
   localparam int FRAME_BITS = 11;          // start + opcode + address
   localparam int OP_POS = 8;               // opcode position in the captured word
   localparam int SUB_POS = 6;              // sub-code position inside the address
   localparam logic [1:0] OP_EXT = 2'h0;    // enable / disable family
   localparam logic [1:0] OP_SET_BOUND = 2'h1;
   localparam logic [1:0] OP_READ = 2'h2;
   localparam logic [1:0] OP_CLEAR = 2'h3;
   localparam logic [1:0] SUB_ON = 2'h3;    // write enable, or unlock with select high
   localparam logic [1:0] SUB_OFF = 2'h0;   // write disable, or permanent lock with select high
   // ------------------------------------------------------------
   // values after reset and after clear
   // ------------------------------------------------------------
   localparam logic [7:0] PROT_ALL_ONES = 8'hFF;  // cleared pattern
   localparam logic [7:0] PROT_RESET = 8'hFF;     // protect register after reset
   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int REF_PERIOD_NS = 10;       // ref_clk period
   localparam int T_WP_NS = 10000;          // self_timed_program_time, plain default
   localparam int WP_CYCLES = (T_WP_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS;
   localparam int SCLK_HALF = 8;            // host serial clock half period in ref cycles
   localparam int CS_GAP_CYCLES = 8;        // host chip select low time between frames, less one cycle
   localparam int POLL_SETTLE = 5;          // host wait before trusting the status pin
   // ------------------------------------------------------------
   // host command set
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      CMD_WEN,
      CMD_WDS,
      CMD_UNLOCK,
      CMD_CLEAR,
      CMD_SET_BOUND,
      CMD_LOCK
   } epr_cmd_t;
   typedef enum logic [1:0] {
      PEND_NONE,
      PEND_CLEAR,
      PEND_BOUND,
      PEND_LOCK
   } epr_pend_t;
endpackage
`default_nettype wire

// File: shared/epr_if.sv
// serial link between host and protect-register device
`default_nettype none
interface epr_if;
   logic chip_select;          // frame, active high
   logic serial_clock;         // link clock made by the host
   logic serial_data_in;       // host to device data
   logic prot_sel;             // protect-register select pin
   logic program_enable_pin;   // program enable pin
   logic sdo_o;                // device status value
   logic sdo_oe_b;             // device drives when low
   wire logic serial_data_out; // resolved pin level, pulled up when released
   // ------------------------------------------------------------
   // pin resolution
   // ------------------------------------------------------------
   // a released pin reads high through its pull-up, so a refused
   // instruction that never shows busy does not stall the poll
   assign serial_data_out = sdo_oe_b ? 1'b1 : sdo_o;
   modport dev (
      input chip_select, serial_clock, serial_data_in, prot_sel, program_enable_pin,
      output sdo_o, sdo_oe_b
   );
   modport host (
      output chip_select, serial_clock, serial_data_in, prot_sel, program_enable_pin,
      input serial_data_out
   );
endinterface
`default_nettype wire

// File: logic/epr_timer.sv
// self-timed programming interval counter
`default_nettype none
module epr_timer #(
   parameter int CYCLES = epr_pkg::WP_CYCLES
) (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic start,
   output logic busy,
   output logic done
);
   localparam int CW = $clog2(CYCLES + 1);
   // ------------------------------------------------------------
   // parameter check
   // ------------------------------------------------------------
   if (CYCLES < 2) begin : g_chk
      $error("epr_timer: CYCLES must be at least 2");
   end
   logic [CW-1:0] cnt_q, cnt_d;   // cycles left, zero when idle
   logic done_q, done_d;          // end-of-interval pulse
   // next state: load on start, count down to zero
   always_comb begin
      cnt_d = cnt_q;
      done_d = 1'b0;
      if (cnt_q != '0) begin
         cnt_d = cnt_q - 1'b1;
         done_d = (cnt_q == {{(CW-1){1'b0}}, 1'b1});
      end else if (start) begin
         cnt_d = CW'(CYCLES);
      end
   end
   // register
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         cnt_q <= '0;
         done_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         done_q <= done_d;
      end
   end
   assign busy = (cnt_q != '0);
   assign done = done_q;
endmodule
`default_nettype wire

// File: logic/epr_device.sv
// protect-register control end of the serial EEPROM
`default_nettype none
// Summary of operation
// - arm only on valid unlock at frame end
// - unlock directly precedes; any instruction consumes arming
// - clear loads all ones into protect register
// - all ones after a clear still allows top address write
// - clear needs arming, enable and select high
// - chip select fall starts self-timed cycle
// - busy, ignores instructions until cycle completes
// - boundary write stores address, protects it and above
// - boundary needs prior clear, arming, pins high
// - permanent lock freezes register until the next reset, once
// - lock needs arming, enable and select high
// - freeze takes effect when lock cycle ends
// - status on data out while selected; else released
// - chip select toggling never aborts the cycle
// - start bit after ready releases data out
// - start bit may begin next command
// - host should not issue commands while busy
// - protect register eight bits, lowest protected address
// - unlock needs write enable and both pins high
// - word write only below boundary, or at any address while cleared to all ones
// - write all only after clear
module epr_device #(
   parameter int WP_CYCLES = epr_pkg::WP_CYCLES
) (
   input wire logic ref_clk,
   input wire logic rst_b,
   epr_if.dev link,
   input wire logic [7:0] wr_addr,
   output logic word_write_ok,
   output logic write_all_ok,
   output logic [7:0] protect_value,
   output logic locked,
   output logic busy
);
   localparam int WORD_W = epr_pkg::FRAME_BITS - 1;
   // ------------------------------------------------------------
   // link domain: reset capture and frame shifter
   // ------------------------------------------------------------
   logic [3:0] lcnt_q, lcnt_d;            // bits taken, zero while hunting a start bit
   logic [WORD_W-1:0] lsh_q, lsh_d;       // opcode and address shifter
   logic [WORD_W-1:0] lword_q, lword_d;   // last complete word, held for the other domain
   logic ldone_q, ldone_d;                // toggles when a word is complete
   logic lstart_q, lstart_d;              // toggles on each start bit
   // next state of the shifter
   always_comb begin
      lcnt_d = lcnt_q;
      lsh_d = lsh_q;
      lword_d = lword_q;
      ldone_d = ldone_q;
      lstart_d = lstart_q;
      if (!link.chip_select) begin
         // deselected: drop any partial frame
         lcnt_d = '0;
      end else if (lcnt_q == '0) begin
         // hunting: a one is the start bit
         if (link.serial_data_in) begin
            lcnt_d = 4'h1;
            lstart_d = ~lstart_q;
         end
      end else begin
         lsh_d = {lsh_q[WORD_W-2:0], link.serial_data_in};
         if (lcnt_q == 4'(WORD_W)) begin
            lword_d = lsh_d;
            ldone_d = ~ldone_q;
            lcnt_d = '0;
         end else begin
            lcnt_d = lcnt_q + 4'h1;
         end
      end
   end
   // register the shifter; the link clock stands still during reset,
   // so reset acts at once here, and it is released while no edge comes
   always_ff @(posedge link.serial_clock or negedge rst_b) begin
      if (!rst_b) begin
         lcnt_q <= '0;
         lsh_q <= '0;
         lword_q <= '0;
         ldone_q <= 1'b0;
         lstart_q <= 1'b0;
      end else begin
         lcnt_q <= lcnt_d;
         lsh_q <= lsh_d;
         lword_q <= lword_d;
         ldone_q <= ldone_d;
         lstart_q <= lstart_d;
      end
   end
   // ------------------------------------------------------------
   // crossings into the ref_clk domain
   // ------------------------------------------------------------
   logic cs_m_q, cs_s_q, cs_p_q;        // chip select sync and previous
   logic pre_m_q, pre_s_q;              // protect select sync
   logic pe_m_q, pe_s_q;                // program enable sync
   logic dn_m_q, dn_s_q, dn_p_q;        // word-complete toggle sync
   logic st_m_q, st_s_q, st_p_q;        // start-bit toggle sync
   // two-stage synchronisers; the first stage is never looked at directly
   always_ff @(posedge ref_clk) begin
      cs_m_q <= link.chip_select;
      cs_s_q <= cs_m_q;
      cs_p_q <= cs_s_q;
      pre_m_q <= link.prot_sel;
      pre_s_q <= pre_m_q;
      pe_m_q <= link.program_enable_pin;
      pe_s_q <= pe_m_q;
      dn_m_q <= ldone_q;
      dn_s_q <= dn_m_q;
      dn_p_q <= dn_s_q;
      st_m_q <= lstart_q;
      st_s_q <= st_m_q;
      st_p_q <= st_s_q;
   end
   logic cs_rise, cs_fall, word_evt, start_evt;
   assign cs_rise = cs_s_q & ~cs_p_q;
   assign cs_fall = cs_p_q & ~cs_s_q;
   assign word_evt = dn_s_q ^ dn_p_q;
   assign start_evt = st_s_q ^ st_p_q;
   // ------------------------------------------------------------
   // command decode and protect state
   // ------------------------------------------------------------
   logic [WORD_W-1:0] cmd_q, cmd_d;     // word of the current frame
   logic cmd_vld_q, cmd_vld_d;          // a full word arrived in this frame
   logic pre_ok_q, pre_ok_d;            // select held high the whole frame
   logic pe_ok_q, pe_ok_d;              // enable held high the whole frame
   logic wen_q, wen_d;                  // write enabled
   logic arm_q, arm_d;                  // protect instructions armed
   logic [7:0] prot_q, prot_d;          // lowest protected address
   logic clr_q, clr_d;                  // cleared since the last boundary write
   logic lock_q, lock_d;                // permanent lock
   logic show_q, show_d;                // status shown on data out
   epr_pkg::epr_pend_t pend_q, pend_d;  // operation awaiting the cycle end
   logic [7:0] pend_addr_q, pend_addr_d;
   logic tmr_start, tmr_busy, tmr_done;
   logic [1:0] op, sub;
   logic [7:0] addr;
   logic exec, prot_go;
   assign op = cmd_q[epr_pkg::OP_POS +: epr_pkg::OP_W];
   assign addr = cmd_q[epr_pkg::ADDR_W-1:0];
   assign sub = addr[epr_pkg::SUB_POS +: 2];
   // frame end with a complete word while idle
   assign exec = cs_fall & cmd_vld_q & ~tmr_busy & ~tmr_done;
   // common qualifier of clear, boundary and lock
   assign prot_go = pre_ok_q & pe_ok_q & arm_q & ~lock_q;
   // next state of decode and protect logic
   always_comb begin
      cmd_d = cmd_q;
      cmd_vld_d = cmd_vld_q;
      pre_ok_d = pre_ok_q & pre_s_q;
      pe_ok_d = pe_ok_q & pe_s_q;
      wen_d = wen_q;
      arm_d = arm_q;
      prot_d = prot_q;
      clr_d = clr_q;
      lock_d = lock_q;
      show_d = show_q;
      pend_d = pend_q;
      pend_addr_d = pend_addr_q;
      tmr_start = 1'b0;
      if (cs_rise) begin
         // new frame: pins must stay high from here on
         pre_ok_d = pre_s_q;
         pe_ok_d = pe_s_q;
      end
      if (word_evt) begin
         cmd_d = lword_q;
         cmd_vld_d = 1'b1;
      end
      if (cs_fall) begin
         // deselect resets the frame
         cmd_vld_d = 1'b0;
      end
      if (exec) begin
         arm_d = 1'b0;
         if (!pre_ok_q) begin
            // memory family: only enable and disable matter here
            if (op == epr_pkg::OP_EXT && sub == epr_pkg::SUB_ON) begin
               wen_d = 1'b1;
            end else if (op == epr_pkg::OP_EXT && sub == epr_pkg::SUB_OFF) begin
               wen_d = 1'b0;
            end
         end else if (op == epr_pkg::OP_EXT && sub == epr_pkg::SUB_ON) begin
            arm_d = wen_q & pe_ok_q;
         end else if (prot_go && op == epr_pkg::OP_CLEAR) begin
            pend_d = epr_pkg::PEND_CLEAR;
         end else if (prot_go && clr_q && op == epr_pkg::OP_SET_BOUND) begin
            pend_d = epr_pkg::PEND_BOUND;
         end else if (prot_go && op == epr_pkg::OP_EXT && sub == epr_pkg::SUB_OFF) begin
            pend_d = epr_pkg::PEND_LOCK;
         end
         // anything else falls through untouched
         if (pend_d != epr_pkg::PEND_NONE) begin
            tmr_start = 1'b1;
            show_d = 1'b1;
            pend_addr_d = addr;
         end
      end
      if (tmr_done) begin
         // apply the pending operation at the end of the interval
         case (pend_q)
            epr_pkg::PEND_CLEAR: begin
               prot_d = epr_pkg::PROT_ALL_ONES;
               clr_d = 1'b1;
            end
            epr_pkg::PEND_BOUND: begin
               prot_d = pend_addr_q;
               clr_d = 1'b0;
            end
            epr_pkg::PEND_LOCK: begin
               lock_d = 1'b1;
            end
            default: begin
            end
         endcase
         pend_d = epr_pkg::PEND_NONE;
      end
      if (start_evt && !tmr_busy && !tmr_done && !tmr_start) begin
         show_d = 1'b0;
      end
   end
   // register decode and protect state
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         cmd_q <= '0;
         cmd_vld_q <= 1'b0;
         pre_ok_q <= 1'b0;
         pe_ok_q <= 1'b0;
         wen_q <= 1'b0;
         arm_q <= 1'b0;
         prot_q <= epr_pkg::PROT_RESET;
         clr_q <= 1'b0;
         lock_q <= 1'b0;
         show_q <= 1'b0;
         pend_q <= epr_pkg::PEND_NONE;
         pend_addr_q <= '0;
      end else begin
         cmd_q <= cmd_d;
         cmd_vld_q <= cmd_vld_d;
         pre_ok_q <= pre_ok_d;
         pe_ok_q <= pe_ok_d;
         wen_q <= wen_d;
         arm_q <= arm_d;
         prot_q <= prot_d;
         clr_q <= clr_d;
         lock_q <= lock_d;
         show_q <= show_d;
         pend_q <= pend_d;
         pend_addr_q <= pend_addr_d;
      end
   end
   // ------------------------------------------------------------
   // self-timed interval, unaffected by chip select
   // ------------------------------------------------------------
   epr_timer #(
      .CYCLES(WP_CYCLES)
   ) u_timer (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .start(tmr_start),
      .busy(tmr_busy),
      .done(tmr_done)
   );
   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   logic sdo_q, sdo_oe_b_q;             // status pin registers
   // busy low, ready high, released while deselected
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         sdo_q <= 1'b1;
         sdo_oe_b_q <= 1'b1;
      end else begin
         sdo_q <= ~tmr_busy;
         sdo_oe_b_q <= ~(cs_s_q & show_q);
      end
   end
   assign link.sdo_o = sdo_q;
   assign link.sdo_oe_b = sdo_oe_b_q;
   // write permission seen by the memory array
   always_comb begin
      word_write_ok = wen_q & ((wr_addr < prot_q) | (clr_q & prot_q == epr_pkg::PROT_ALL_ONES));
      write_all_ok = wen_q & clr_q;
   end
   assign protect_value = prot_q;
   assign locked = lock_q;
   assign busy = tmr_busy;
endmodule
`default_nettype wire

// File: logic/epr_host.sv
// host end: issues protect instructions and polls status
`default_nettype none
module epr_host (
   input wire logic ref_clk,
   input wire logic rst_b,
   epr_if.host link,
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire epr_pkg::epr_cmd_t cmd,
   input wire logic [7:0] cmd_addr,
   input wire logic pe_level,
   output logic done
);
   typedef enum logic [2:0] {H_IDLE, H_SHIFT, H_GAP, H_POLL, H_DONE} epr_hst_t;
   localparam int DIV_W = $clog2(2 * epr_pkg::SCLK_HALF);
   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   epr_hst_t st_q, st_d;                    // sequencer state
   logic [epr_pkg::FRAME_BITS-1:0] fr_q, fr_d; // outgoing frame
   logic [3:0] bit_q, bit_d;                // bits sent
   logic [DIV_W-1:0] div_q, div_d;          // serial clock divider
   logic [3:0] gap_q, gap_d;                // wait counter
   logic prog_q, prog_d;                    // instruction starts a timed cycle
   logic cs_q, cs_d, sk_q, sk_d, di_q, di_d, pre_q, pre_d, pe_q;
   logic sdo_m_q, sdo_s_q;                  // status pin sync
   logic [1:0] op;
   logic [7:0] ad;
   // instruction encoding
   always_comb begin
      op = epr_pkg::OP_EXT;
      ad = cmd_addr;
      case (cmd)
         epr_pkg::CMD_WEN, epr_pkg::CMD_UNLOCK: ad = {epr_pkg::SUB_ON, 6'h00};
         epr_pkg::CMD_WDS, epr_pkg::CMD_LOCK: ad = {epr_pkg::SUB_OFF, 6'h00};
         epr_pkg::CMD_CLEAR: op = epr_pkg::OP_CLEAR;
         epr_pkg::CMD_SET_BOUND: op = epr_pkg::OP_SET_BOUND;
         default: op = epr_pkg::OP_EXT;
      endcase
   end
   // next state
   always_comb begin
      st_d = st_q;
      fr_d = fr_q;
      bit_d = bit_q;
      div_d = div_q;
      gap_d = gap_q;
      prog_d = prog_q;
      cs_d = cs_q;
      sk_d = 1'b0;
      di_d = di_q;
      pre_d = pre_q;
      case (st_q)
         H_IDLE: begin
            if (cmd_valid) begin
               fr_d = {1'b1, op, ad};
               pre_d = (cmd != epr_pkg::CMD_WEN) && (cmd != epr_pkg::CMD_WDS);
               prog_d = (cmd == epr_pkg::CMD_CLEAR) || (cmd == epr_pkg::CMD_SET_BOUND) ||
                        (cmd == epr_pkg::CMD_LOCK);
               cs_d = 1'b1;
               bit_d = '0;
               div_d = '0;
               st_d = H_SHIFT;
            end
         end
         H_SHIFT: begin
            div_d = div_q + 1'b1;
            sk_d = (div_d >= DIV_W'(epr_pkg::SCLK_HALF));
            if (div_q == '0) begin
               if (bit_q == 4'(epr_pkg::FRAME_BITS)) begin
                  // drop select before the next rising edge
                  cs_d = 1'b0;
                  sk_d = 1'b0;
                  gap_d = '0;
                  st_d = H_GAP;
               end else begin
                  di_d = fr_q[epr_pkg::FRAME_BITS-1];
                  fr_d = {fr_q[epr_pkg::FRAME_BITS-2:0], 1'b0};
                  bit_d = bit_q + 4'h1;
               end
            end
         end
         H_GAP: begin
            gap_d = gap_q + 4'h1;
            if (gap_q == 4'(epr_pkg::CS_GAP_CYCLES)) begin
               gap_d = '0;
               di_d = 1'b0;
               if (prog_q) begin
                  cs_d = 1'b1;
                  st_d = H_POLL;
               end else begin
                  st_d = H_DONE;
               end
            end
         end
         H_POLL: begin
            // wait for ready before issuing anything else
            if (gap_q != 4'(epr_pkg::POLL_SETTLE)) begin
               gap_d = gap_q + 4'h1;
            end else if (sdo_s_q == 1'b1) begin
               cs_d = 1'b0;
               st_d = H_DONE;
            end
         end
         H_DONE: begin
            st_d = H_IDLE;
         end
         default: st_d = H_IDLE;
      endcase
   end
   // register
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         st_q <= H_IDLE;
         fr_q <= '0;
         bit_q <= '0;
         div_q <= '0;
         gap_q <= '0;
         prog_q <= 1'b0;
         cs_q <= 1'b0;
         sk_q <= 1'b0;
         di_q <= 1'b0;
         pre_q <= 1'b0;
         pe_q <= 1'b0;
      end else begin
         st_q <= st_d;
         fr_q <= fr_d;
         bit_q <= bit_d;
         div_q <= div_d;
         gap_q <= gap_d;
         prog_q <= prog_d;
         cs_q <= cs_d;
         sk_q <= sk_d;
         di_q <= di_d;
         pre_q <= pre_d;
         pe_q <= pe_level;
      end
   end
   // status pin synchroniser
   always_ff @(posedge ref_clk) begin
      sdo_m_q <= link.serial_data_out;
      sdo_s_q <= sdo_m_q;
   end
   assign link.chip_select = cs_q;
   assign link.serial_clock = sk_q;
   assign link.serial_data_in = di_q;
   assign link.prot_sel = pre_q;
   assign link.program_enable_pin = pe_q;
   assign cmd_ready = (st_q == H_IDLE);
   assign done = (st_q == H_DONE);
endmodule
`default_nettype wire

// File: tb/epr_link_checker.sv
// assertions on the serial link between host and device
`default_nettype none
module epr_link_checker (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic chip_select,
   input wire logic serial_clock,
   input wire logic serial_data_in,
   input wire logic prot_sel,
   input wire logic sdo_o,
   input wire logic sdo_oe_b
);
   // --------------------------------------------------
   // link properties
   // --------------------------------------------------
   localparam int BUSY_MAX = 60; // bound on the busy display, well above the 20-cycle bench timer
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_b);
   sequence ready_shown;
      !sdo_oe_b && sdo_o;
   endsequence
   sequence start_bit;
      $rose(serial_clock) && serial_data_in && chip_select;
   endsequence
   a_idle_sclk_low: assert property (!chip_select |-> !serial_clock) else $error("clock runs outside frame");
   a_frame_end_low: assert property ($fell(chip_select) |-> !$past(serial_clock)) else $error("frame ended late");
   a_sclk_high_len: assert property ($rose(serial_clock) |-> serial_clock[*8] ##1 !serial_clock)
      else $error("clock high time wrong");
   a_din_stable: assert property (serial_clock && $past(serial_clock) |-> $stable(serial_data_in))
      else $error("data moved while clock high");
   a_select_steady: assert property (chip_select && $past(chip_select) |-> $stable(prot_sel))
      else $error("select pin moved in frame");
   a_released_cs_low: assert property (!chip_select[*6] |-> sdo_oe_b) else $error("data out driven");
   a_ready_held: assert property (ready_shown ##1 !sdo_oe_b |-> sdo_o) else $error("ready fell back");
   a_busy_bounded: assert property (!sdo_oe_b && !sdo_o |-> ##[1:BUSY_MAX] (sdo_o || sdo_oe_b))
      else $error("busy never ended");
   a_start_releases: assert property (ready_shown ##0 start_bit |-> ##[1:8] sdo_oe_b)
      else $error("status not cleared");
endmodule
`default_nettype wire

// File: tb/tb_top.sv
// self-checking bench: host and device joined over the serial link
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int WP = 20; // shortened self-timed interval
   logic ref_clk = 1'b0;
   logic rst_b = 1'b0;
   logic cmd_valid = 1'b0;
   logic pe_level = 1'b1;
   logic [7:0] cmd_addr = 8'h00;
   logic [7:0] wr_addr = 8'h00;
   epr_pkg::epr_cmd_t cmd = epr_pkg::CMD_WEN;
   logic cmd_ready, done, word_write_ok, write_all_ok, locked, busy;
   logic [7:0] protect_value, a;
   logic [31:0] rng_q = 32'h3269; // xorshift state
   int fail_count = 0;
   int checked = 0;
   int busy_run = 0;
   int busy_len = 0;
   epr_if link ();
   epr_host epr_host_i (.ref_clk(ref_clk), .rst_b(rst_b), .link(link.host), .cmd_valid(cmd_valid),
      .cmd_ready(cmd_ready), .cmd(cmd), .cmd_addr(cmd_addr), .pe_level(pe_level), .done(done));
   epr_device #(.WP_CYCLES(WP)) epr_device_i (.ref_clk(ref_clk), .rst_b(rst_b), .link(link.dev),
      .wr_addr(wr_addr), .word_write_ok(word_write_ok), .write_all_ok(write_all_ok),
      .protect_value(protect_value), .locked(locked), .busy(busy));
   epr_link_checker epr_link_checker_i (.ref_clk(ref_clk), .rst_b(rst_b), .chip_select(link.chip_select),
      .serial_clock(link.serial_clock), .serial_data_in(link.serial_data_in), .prot_sel(link.prot_sel),
      .sdo_o(link.sdo_o), .sdo_oe_b(link.sdo_oe_b));
   always #5 ref_clk = ~ref_clk;
   // measures the length of the last busy interval
   always @(posedge ref_clk) begin
      busy_run <= (busy === 1'b1) ? busy_run + 1 : 0;
      if (busy !== 1'b1 && busy_run != 0) begin
         busy_len <= busy_run;
      end
   end
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %s expected %0h seen %0h", what, exp, got);
      end
   endtask
   task automatic complete_run();
      $display("checked %0d fail_count %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // one command through the host, bounded wait for done
   task automatic issue(input epr_pkg::epr_cmd_t c, input logic [7:0] ad, input logic pe);
      int n;
      @(posedge ref_clk);
      pe_level <= pe;
      @(negedge ref_clk);
      chk("cmd ready", 8'h01, {7'h00, cmd_ready});
      @(posedge ref_clk);
      cmd_valid <= 1'b1;
      cmd <= c;
      cmd_addr <= ad;
      @(posedge ref_clk);
      cmd_valid <= 1'b0;
      n = 0;
      while (done !== 1'b1 && n < 2000) begin
         @(negedge ref_clk);
         n++;
      end
      if (n >= 2000) begin
         fail_count++;
         complete_run();
      end
   endtask
   task automatic probe(input logic [7:0] w, input logic e);
      @(posedge ref_clk);
      wr_addr <= w;
      @(negedge ref_clk);
      chk("word write", {7'h00, e}, {7'h00, word_write_ok});
   endtask
   // --------------------------------------------------
   // main sequence
   // --------------------------------------------------
   initial begin
      repeat (6) @(posedge ref_clk);
      rst_b <= 1'b1;
      @(negedge ref_clk);
      chk("protect", 8'hFF, protect_value);
      issue(epr_pkg::CMD_WEN, 8'h00, 1'b1);
      issue(epr_pkg::CMD_CLEAR, 8'h00, 1'b1);
      chk("write all", 8'h00, {7'h00, write_all_ok});
      issue(epr_pkg::CMD_UNLOCK, 8'h00, 1'b0);
      issue(epr_pkg::CMD_CLEAR, 8'h00, 1'b1);
      chk("write all", 8'h00, {7'h00, write_all_ok});
      for (int i = 0; i < 4; i++) begin
         rng_q = xs(rng_q);
         a = (i == 0) ? 8'h00 : rng_q[7:0];
         issue(epr_pkg::CMD_UNLOCK, 8'h00, 1'b1);
         issue(epr_pkg::CMD_CLEAR, 8'h00, 1'b1);
         chk("busy length", WP[7:0], busy_len[7:0]);
         chk("protect", 8'hFF, protect_value);
         chk("write all", 8'h01, {7'h00, write_all_ok});
         probe(8'hFF, 1'b1);
         issue(epr_pkg::CMD_UNLOCK, 8'h00, 1'b1);
         issue(epr_pkg::CMD_SET_BOUND, a, 1'b1);
         chk("protect", a, protect_value);
         probe(i[0] ? a : rng_q[15:8], (i[0] ? a : rng_q[15:8]) < a);
      end
      issue(epr_pkg::CMD_UNLOCK, 8'h00, 1'b1);
      issue(epr_pkg::CMD_SET_BOUND, ~a, 1'b1);
      chk("protect", a, protect_value);
      issue(epr_pkg::CMD_UNLOCK, 8'h00, 1'b1);
      issue(epr_pkg::CMD_WEN, 8'h00, 1'b1);
      issue(epr_pkg::CMD_CLEAR, 8'h00, 1'b1);
      chk("protect", a, protect_value);
      issue(epr_pkg::CMD_UNLOCK, 8'h00, 1'b1);
      issue(epr_pkg::CMD_LOCK, 8'h00, 1'b1);
      chk("locked", 8'h01, {7'h00, locked});
      issue(epr_pkg::CMD_UNLOCK, 8'h00, 1'b1);
      issue(epr_pkg::CMD_CLEAR, 8'h00, 1'b1);
      chk("protect", a, protect_value);
      issue(epr_pkg::CMD_WDS, 8'h00, 1'b1);
      probe(8'h00, 1'b0);
      complete_run();
   end
endmodule
`default_nettype wire
